// File: dac_chain_cfg.svh
`ifndef DAC_CHAIN_CFG_SVH
`define DAC_CHAIN_CFG_SVH
// Register word indices, byte address is index times four
`define IDX_CTRL   5'h00
`define IDX_HP     5'h01
`define IDX_LP     5'h02
`define IDX_EMPH   5'h03
`define IDX_SHAC   5'h04
`define IDX_SHB    5'h05
`define IDX_ALC    5'h06
`define IDX_STAT   5'h07
`define IDX_BAND0  5'h08
`define REG_COUNT  18
// Control word fields
`define CTRL_HP_EN    0
`define CTRL_LP_EN    1
`define CTRL_SHELF_EN 2
`define CTRL_EMPH_SEL 3
`define CTRL_ALC_EN   4
`define CTRL_DAC_ON   5
`define CTRL_GAIN_LO  6
`define CTRL_BAND_LO  8
`define CTRL_EMPH_EN  13
`define CTRL_MASK     32'h0000_3fff
// Pair layouts: A low half, B/C high half
`define COEF14_MASK   32'h3fff_3fff
`define ALC_MASK      32'h00ff_ffff
// Everything clears to zero
`define REG_RESET     32'h0000_0000
// Coefficient fraction bits
`define COEF_FRAC     13
// AXI answers
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: dac_chain_checker.sv
`default_nettype none
module dac_chain_checker (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic [7:0]             s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic                   in_valid,
	input wire logic                   in_ready,
	input wire logic                   out_valid,
	input wire logic                   out_ready,
	input wire dac_chain_pkg::stereo_t out_sample
);
	logic [1:0] fill;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Own count of buffered frames, so refusal is judged apart from the design
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fill <= 2'h0;
		else
			fill <= fill + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
	end
	property p_reset_clear;
		$rose(aresetn) |-> !out_valid && !s_axi_rvalid && !s_axi_bvalid;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("valid high after reset");
	property p_one_frame; in_valid && in_ready && !out_valid |=> out_valid; endproperty
	a_one_frame: assert property (p_one_frame) else $error("accepted frame not offered");
	property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_sample); endproperty
	a_out_hold: assert property (p_out_hold) else $error("output frame lost in stall");
	property p_refuse; in_ready == (fill != 2'h2); endproperty
	a_refuse: assert property (p_refuse) else $error("input ready disagrees with fill");
	property p_rd_err; s_axi_arvalid && s_axi_arready && s_axi_araddr[7]
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
	property p_b_after; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid; endproperty
	a_b_after: assert property (p_b_after) else $error("write response late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule
bind dac_playback_filter_chain dac_chain_checker i_dac_chain_checker (.*);
`default_nettype wire

// File: dac_chain_pkg.sv
`include "dac_chain_cfg.svh"
`default_nettype none
package dac_chain_pkg;
	typedef logic signed [23:0] sample_t;
	typedef logic signed [47:0] acc_t;
	typedef logic signed [15:0] coef_t;
	typedef struct packed {
		sample_t left;
		sample_t right;
	} stereo_t;
	typedef struct packed {
		sample_t       hp_x;
		sample_t       hp_y;
		sample_t       lp_x;
		sample_t       lp_y;
		sample_t       em_x;
		sample_t       em_y;
		sample_t       sh_x;
		sample_t       sh_y;
		sample_t       bq_x1;
		sample_t       bq_x2;
		logic [4:0][23:0] bq_y1;
		logic [4:0][23:0] bq_y2;
	} chan_t;
	typedef struct packed {
		logic [`REG_COUNT-1:0][31:0] regs;
		chan_t [1:0]      chan;
		stereo_t [1:0]    fifo;
		logic             wr_ptr;
		logic             rd_ptr;
		logic [1:0]       fill;
		logic [15:0]      samples;
		logic             aw_got;
		logic             w_got;
		logic [4:0]       aw_idx;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} state_t;
endpackage
`default_nettype wire

// File: dac_playback_filter_chain.sv
`include "dac_chain_cfg.svh"
`default_nettype none
module dac_playback_filter_chain (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      in_valid,
	output logic                           in_ready,
	input  wire dac_chain_pkg::stereo_t    in_sample,
	output logic                           out_valid,
	input  wire logic                      out_ready,
	output dac_chain_pkg::stereo_t         out_sample
);
	dac_chain_pkg::state_t s;
	dac_chain_pkg::state_t next_s;

	// Writable bits of each word; unmapped words give none
	function automatic logic [31:0] wmask(input logic [4:0] idx);
		if (idx == `IDX_CTRL)
			return `CTRL_MASK;
		else if (idx == `IDX_HP || idx == `IDX_LP || idx == `IDX_EMPH)
			return `COEF14_MASK;
		else if (idx == `IDX_SHAC)
			return 32'hffff_ffff;
		else if (idx == `IDX_SHB)
			return 32'h0000_3fff;
		else if (idx == `IDX_ALC)
			return `ALC_MASK;
		else if (idx >= `IDX_BAND0 && idx < 5'(`REG_COUNT) && idx[0])
			return 32'h0000_ffff;
		else if (idx >= `IDX_BAND0 && idx < 5'(`REG_COUNT))
			return 32'hffff_ffff;
		else
			return 32'h0000_0000;
	endfunction

	// Decode shared by read and write paths
	function automatic logic mapped(input logic [4:0] idx);
		return (idx == `IDX_STAT) || (wmask(idx) != 32'h0000_0000);
	endfunction

	// Sign-extend a 14-bit coefficient field
	function automatic dac_chain_pkg::coef_t c14(input logic [13:0] v);
		return dac_chain_pkg::coef_t'($signed(v));
	endfunction

	// Full-width product; no overflow at these widths
	function automatic dac_chain_pkg::acc_t mul(input dac_chain_pkg::acc_t v,
		input dac_chain_pkg::coef_t c);
		return v * dac_chain_pkg::acc_t'(c);
	endfunction

	// Drop fraction bits and clip to sample range
	function automatic dac_chain_pkg::sample_t sat(input dac_chain_pkg::acc_t v);
		dac_chain_pkg::acc_t q;
		q = v >>> `COEF_FRAC;
		if (q > 48'sh7f_ffff)
			return 24'sh7f_ffff;
		else if (q < -48'sh80_0000)
			return 24'sh80_0000;
		else
			return q[23:0];
	endfunction

	// Clip an unscaled sum to sample range
	function automatic dac_chain_pkg::sample_t clip(input dac_chain_pkg::acc_t v);
		return sat(v <<< `COEF_FRAC);
	endfunction

	// Widen a sample for arithmetic
	function automatic dac_chain_pkg::acc_t w(input logic [23:0] v);
		return dac_chain_pkg::acc_t'($signed(v));
	endfunction

	// First-order section; lowpass form sums taps, highpass differences them
	function automatic dac_chain_pkg::sample_t order1(input dac_chain_pkg::sample_t x,
		input dac_chain_pkg::sample_t x1, input dac_chain_pkg::sample_t y1,
		input dac_chain_pkg::coef_t a, input dac_chain_pkg::coef_t b, input logic low);
		dac_chain_pkg::acc_t t;
		t = low ? (w(x) + w(x1)) : (w(x) - w(x1));
		return sat(mul(t, a) - mul(w(y1), b));
	endfunction

	// Shelf section: y = A x + C x1 - B y1; A and C are full 16-bit words
	function automatic dac_chain_pkg::sample_t shelf(input dac_chain_pkg::sample_t x,
		input dac_chain_pkg::sample_t x1, input dac_chain_pkg::sample_t y1,
		input dac_chain_pkg::coef_t a, input dac_chain_pkg::coef_t c,
		input dac_chain_pkg::coef_t b);
		dac_chain_pkg::acc_t t;
		t = mul(w(x), a) + mul(w(x1), c);
		return sat(t - mul(w(y1), b));
	endfunction

	// One band: A (x - x2) + B y1 + C y2, zeros at DC and half rate
	function automatic dac_chain_pkg::sample_t band(input dac_chain_pkg::sample_t x,
		input dac_chain_pkg::sample_t x2, input logic [23:0] y1, input logic [23:0] y2,
		input dac_chain_pkg::coef_t a, input dac_chain_pkg::coef_t b,
		input dac_chain_pkg::coef_t c);
		dac_chain_pkg::acc_t t;
		t = mul(w(x) - w(x2), a) + mul(w(y1), b);
		return sat(t + mul(w(y2), c));
	endfunction

	// Level control reduced to a symmetric clamp; no attack or release ramps
	function automatic dac_chain_pkg::sample_t limit(input dac_chain_pkg::sample_t x,
		input logic [23:0] level, input logic en);
		dac_chain_pkg::acc_t top;
		top = w(level);
		// Disabled control leaves the chain output untouched
		if (!en)
			return x;
		else if (w(x) > top)
			return level;
		else if (w(x) < -top)
			return -level;
		else
			return x;
	endfunction

	// Byte-lane merge; reserved bits always land as zero
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				m[8*b +: 8] = d[8*b +: 8] & mask[8*b +: 8];
		end
		return m;
	endfunction

	// One channel through the whole chain, one sample per call
	function automatic void step(input dac_chain_pkg::sample_t x,
		input dac_chain_pkg::chan_t st, input logic [`REG_COUNT-1:0][31:0] r,
		output dac_chain_pkg::chan_t ns, output dac_chain_pkg::sample_t y);
		dac_chain_pkg::sample_t hp;
		dac_chain_pkg::sample_t lp;
		dac_chain_pkg::sample_t em;
		dac_chain_pkg::sample_t sh;
		dac_chain_pkg::sample_t g;
		dac_chain_pkg::sample_t lim;
		dac_chain_pkg::acc_t    sum;
		dac_chain_pkg::sample_t bq;
		logic [31:0]            ctrl;
		logic [31:0]            bc;
		logic [31:0]            bd;
		ctrl = r[`IDX_CTRL];
		ns = st;
		sum = w(24'h00_0000);
		// High-pass, A low half, B high half
		if (ctrl[`CTRL_HP_EN])
			hp = order1(x, st.hp_x, st.hp_y, c14(r[`IDX_HP][13:0]),
				c14(r[`IDX_HP][29:16]), 1'b0);
		else
			hp = x;
		ns.hp_x = x;
		ns.hp_y = hp;
		// Low-pass
		if (ctrl[`CTRL_LP_EN])
			lp = order1(hp, st.lp_x, st.lp_y, c14(r[`IDX_LP][13:0]),
				c14(r[`IDX_LP][29:16]), 1'b1);
		else
			lp = hp;
		ns.lp_x = hp;
		ns.lp_y = lp;
		// Emphasis; its A also sets the emphasis attenuation
		if (ctrl[`CTRL_EMPH_EN])
			em = order1(lp, st.em_x, st.em_y, c14(r[`IDX_EMPH][13:0]),
				c14(r[`IDX_EMPH][29:16]), ctrl[`CTRL_EMPH_SEL]);
		else
			em = lp;
		ns.em_x = lp;
		ns.em_y = em;
		// Shelf: y = A x + C x1 - B y1
		if (ctrl[`CTRL_SHELF_EN])
			sh = shelf(em, st.sh_x, st.sh_y, r[`IDX_SHAC][15:0], r[`IDX_SHAC][31:16],
				c14(r[`IDX_SHB][13:0]));
		else
			sh = em;
		ns.sh_x = em;
		ns.sh_y = sh;
		// Compensation gain as a left shift; the shelf A scales the rest
		g = clip(w(sh) <<< ctrl[`CTRL_GAIN_LO +: 2]);
		// Parallel biquads share the input delay line
		for (int n = 0; n < 5; n++) begin
			bc = r[`IDX_BAND0 + 2 * n];
			bd = r[`IDX_BAND0 + 2 * n + 1];
			if (ctrl[`CTRL_BAND_LO + n]) begin
				bq = band(g, st.bq_x2, st.bq_y1[n], st.bq_y2[n], bc[15:0], bc[31:16],
					bd[15:0]);
				ns.bq_y1[n] = bq;
				sum = sum + w(bq);
			end else begin
				// Idle band clears y1 now and y2 one sample later; adds nothing to the sum
				ns.bq_y1[n] = 24'h00_0000;
			end
			ns.bq_y2[n] = st.bq_y1[n];
		end
		ns.bq_x1 = g;
		ns.bq_x2 = st.bq_x1;
		lim = clip(w(g) + sum);
		// Level control last, on the summed output
		y = limit(lim, r[`IDX_ALC][23:0], ctrl[`CTRL_ALC_EN]);
	endfunction

	// Next-state logic for bus, chain and output buffer
	always_comb begin
		dac_chain_pkg::chan_t   nch;
		dac_chain_pkg::sample_t yl;
		dac_chain_pkg::sample_t yr;
		logic                   push;
		logic                   pop;
		logic [4:0]             ridx;
		nch = s.chan[0];
		yl = 24'h00_0000;
		yr = 24'h00_0000;
		next_s = s;
		ridx = s_axi_araddr[6:2];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;

		// Address and data may come in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_idx = s_axi_awaddr[7] ? 5'h1f : s_axi_awaddr[6:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.aw_got && s.w_got) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = mapped(s.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
			if (wmask(s.aw_idx) != 32'h0000_0000)
				next_s.regs[s.aw_idx] = merge(s.regs[s.aw_idx], s.wdata, s.wstrb,
					wmask(s.aw_idx));
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;

		// Reads: status shows sample count and buffer fill
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = `RESP_SLVERR;
			next_s.rdata = 32'h0000_0000;
			if (s_axi_araddr[7]) begin
				next_s.rresp = `RESP_SLVERR;
			end else if (ridx == `IDX_STAT) begin
				next_s.rresp = `RESP_OKAY;
				next_s.rdata = {14'h0000, s.fill, s.samples};
			end else if (mapped(ridx)) begin
				next_s.rresp = `RESP_OKAY;
				next_s.rdata = s.regs[ridx];
			end
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end

		// One stereo sample per accepted input
		if (push) begin
			if (s.regs[`IDX_CTRL][`CTRL_DAC_ON]) begin
				step(in_sample.left, s.chan[0], s.regs, nch, yl);
				next_s.chan[0] = nch;
				step(in_sample.right, s.chan[1], s.regs, nch, yr);
				next_s.chan[1] = nch;
			end else begin
				// Powered down: history cleared, samples pass raw
				next_s.chan = '0;
				yl = in_sample.left;
				yr = in_sample.right;
			end
			next_s.fifo[s.wr_ptr] = '{left: yl, right: yr};
			next_s.wr_ptr = ~s.wr_ptr;
			next_s.samples = s.samples + 16'h0001;
		end
		if (pop)
			next_s.rd_ptr = ~s.rd_ptr;
		if (push && !pop)
			next_s.fill = s.fill + 2'h1;
		else if (pop && !push)
			next_s.fill = s.fill - 2'h1;
	end

	// Whole state clears to zero, coefficients included
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	// Write side takes nothing more until its answer is taken
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready  = !s.w_got && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;

	// One read at a time; a new address waits for the data to go
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	// A full buffer stalls the source rather than drop a frame
	assign in_ready      = s.fill != 2'h2;
	assign out_valid     = s.fill != 2'h0;
	assign out_sample    = s.fifo[s.rd_ptr];
endmodule
`default_nettype wire

// File: dac_playback_filter_chain_bench.sv
`default_nettype none
module dac_playback_filter_chain_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [31:0]            ctrl;
		logic [31:0]            level;
		dac_chain_pkg::stereo_t din;
		dac_chain_pkg::stereo_t dout;
	} row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic in_valid, in_ready, out_valid, out_ready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	dac_chain_pkg::stereo_t in_sample, out_sample, got;
	int errors = 0;
	int tests_run = 0;
	logic [7:0]  ra [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h00};
	logic [31:0] rx [8] = '{32'h3fff3fff, 32'h3fff3fff, 32'h3fff3fff, 32'hffffffff,
		32'h00003fff, 32'hffffffff, 32'h0000ffff, 32'h00003fff};
	// Dac off, all stages off, level clamp on, level clamp off
	row_t rows [4] = '{
		'{32'h0, 32'h0, 48'h123456fedcba, 48'h123456fedcba},
		'{32'h20, 32'h0, 48'h7fffff800001, 48'h7fffff800001},
		'{32'h30, 32'h1000, 48'h7fffff800001, 48'h001000fff000},
		'{32'h20, 32'h1000, 48'h7fffff800001, 48'h7fffff800001}};
	dac_playback_filter_chain i_dac_playback_filter_chain (.*);
	sample_source i_sample_source (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic check32(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic check48(input dac_chain_pkg::stereo_t g, input dac_chain_pkg::stereo_t e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t frame %h expected %h", $time, g, e);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic take(output dac_chain_pkg::stereo_t s);
		@(posedge aclk);
		out_ready <= 1'b1;
		do @(posedge aclk); while (!out_valid);
		s = out_sample;
		out_ready <= 1'b0;
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#50us;
		errors++;
		end_sim();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, out_ready, aresetn} = '0;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			axi_read(8'(i * 4), rd, resp);
			check32(rd, 32'h0);
		end
		$display("reset values done");
		// Coefficients first, stages still bypassed while they change
		for (int i = 0; i < 8; i++) begin
			axi_write(ra[i], 32'hffffffff, resp);
			axi_read(ra[i], rd, resp);
			check32(rd, rx[i]);
		end
		$display("register widths done");
		foreach (rows[i]) begin
			axi_write(8'h00, rows[i].ctrl, resp);
			axi_write(8'h18, rows[i].level, resp);
			i_sample_source.send(rows[i].din);
			take(got);
			check48(got, rows[i].dout);
			$display("row %0d done", i);
		end
		axi_read(8'h80, rd, resp);
		check32({resp, rd[29:0]}, 32'h80000000);
		axi_write(8'h80, 32'h1, resp);
		check32({30'h0, resp}, 32'h2);
		$display("unmapped done");
		// Receiver stalls, two frames must be kept, and input ready must then be low
		i_sample_source.send(48'h000001000002);
		i_sample_source.send(48'h000003000004);
		@(posedge aclk);
		check32({31'h0, in_ready}, 32'h0);
		take(got);
		check48(got, 48'h000001000002);
		take(got);
		check48(got, 48'h000003000004);
		$display("stall done");
		// Powered-down frame clears history; coefficients set while bypassed
		axi_write(8'h00, 32'h0, resp);
		i_sample_source.send(48'h0);
		take(got);
		check48(got, 48'h0);
		axi_write(8'h10, 32'h00002000, resp);
		axi_write(8'h14, 32'h0, resp);
		axi_write(8'h20, 32'h00002000, resp);
		axi_write(8'h24, 32'h0, resp);
		// Unity shelf, gain of two, first band at unity: output is four times input
		axi_write(8'h00, 32'h164, resp);
		i_sample_source.send(48'h000100ffff00);
		take(got);
		check48(got, 48'h000400fffc00);
		// Single byte lane into the level word
		s_axi_wstrb <= 4'h2;
		axi_write(8'h18, 32'hffffffff, resp);
		s_axi_wstrb <= 4'hf;
		axi_read(8'h18, rd, resp);
		check32(rd, 32'h0000ff00);
		$display("filter done");
		// Reset in mid-run must clear control and coefficients
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(8'h00, rd, resp);
		check32(rd, 32'h0);
		axi_read(8'h20, rd, resp);
		check32(rd, 32'h0);
		$display("mid reset done");
		end_sim();
	end
endmodule
`default_nettype wire

// File: sample_source.sv
`default_nettype none
module sample_source (
	input  wire logic                  aclk,
	input  wire logic                  in_ready,
	output var logic                   in_valid,
	output var dac_chain_pkg::stereo_t in_sample
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		in_valid = 1'b0;
		in_sample = 48'h0;
	end
	// Offer one frame and hold it until taken
	task automatic send(input dac_chain_pkg::stereo_t s);
		@(posedge aclk);
		in_valid <= 1'b1;
		in_sample <= s;
		do @(posedge aclk); while (!in_ready);
		in_valid <= 1'b0;
		in_sample <= ~s; // Stale data must not look valid
	endtask
endmodule
`default_nettype wire
